//--- rtl/ebs_sequencer.sv
// external bus cycle sequencer with window decode and S0..S5 half-clock states
// What the document requires
// (RULE1) each cycle start compares the address with eight select and two dram windows
// (RULE2) one hit asserts that select or dram block and uses its settings
// (RULE3) no hit runs external ack, burst-inhibited, 32-bit cycle
// (RULE4) several select hits drive all of them, external ack, no burst, 32-bit
// (RULE5) software must avoid dram-dram or dram-select overlaps; result undefined
// (RULE6) basic cycle is three bus clocks; strobe falls mid first clock
// (RULE7) on reads data and ack sampled at rising edge ending second clock
// (RULE8) write data driven from end of first clock until cycle end
// (RULE9) missing ack inserts whole-clock wait states until seen
// (RULE10) ack internal when window enables it, else external party drives it
// (RULE11) last clock holds address, attributes and write data
// (RULE12) even states while bus clock high, odd states while low
// (RULE13) S0 drives address, in-progress, read/write, type, modifier, size, start
// (RULE14) S1 asserts address strobe, select, lanes and output enable; the code asserts output enable on reads only
// (RULE15) ack seen during S1 skips S2 and S3
// (RULE16) S2 negates transfer start
// (RULE17) target negates ack in S4 and frees the data bus by S5
// (RULE18) S5 negates strobes at fall, drops address and attributes at rise
// (RULE19) back-to-back cycle keeps in-progress asserted
// (RULE20) type, modifier, in-progress reach pins only when pin config selects them
// (RULE21) outputs launch on rising bus edges; strobes change on falling edges
// (RULE22) size code 00 long, 01 byte, 10 word, 11 line
// (RULE23) target three-states data within two bus clocks of S4
// (RULE24) reset returns idle, strobes negated, outputs inactive, data released
// (RULE25) internal ack comes after programmed wait states with external timing
`timescale 1ns/1ns
`default_nettype none
module ebs_sequencer (
    input wire logic clk,
    input wire logic rst_n,
    input wire ebs_pkg::ebs_win_t [ebs_pkg::NUM_CS-1:0] select_window_config,
    input wire ebs_pkg::ebs_dwin_t [ebs_pkg::NUM_DRAM-1:0] dram_block_config,
    input wire logic [2:0] pin_assign_config,
    input wire logic req_valid,
    input wire ebs_pkg::ebs_req_t req,
    output logic req_ready,
    output logic done,
    output logic [31:0] rdata,
    output logic undefined_access,
    output logic [ebs_pkg::NUM_DRAM-1:0] dram_block_sel,
    output logic bus_clock_out,
    output logic [31:0] addr_out,
    output logic addr_oe_n,
    output logic read_write,
    output logic [1:0] xfer_size_code,
    output logic [1:0] xfer_type_code,
    output logic [2:0] xfer_modifier_code,
    output logic transfer_start_n,
    output logic transfer_in_progress_n,
    output logic addr_strobe_n,
    output logic [ebs_pkg::NUM_CS-1:0] window_select_n,
    output logic [3:0] byte_lane_enable_n,
    output logic output_enable_n,
    input wire logic transfer_ack_n,
    input wire logic [31:0] data_in,
    output logic [31:0] data_out,
    output logic data_oe_n,
    output logic transfer_ack_out_n,
    output logic transfer_ack_oe_n
);
    import ebs_pkg::*;

    // pins pass two flops before use
    logic ack_m_q, ack_s_q;
    logic [31:0] din_m_q, din_s_q;
    always_ff @(posedge clk) begin
        ack_m_q <= transfer_ack_n;
        ack_s_q <= ack_m_q;
        din_m_q <= data_in;
        din_s_q <= din_m_q;
    end

    // (RULE1) window compare
    logic [NUM_CS-1:0] cs_hit;
    logic [NUM_DRAM-1:0] dram_hit;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CS; gi++) begin : g_cs
            assign cs_hit[gi] = select_window_config[gi].valid &&
                ((req.addr & ~select_window_config[gi].mask) ==
                 (select_window_config[gi].base & ~select_window_config[gi].mask));
        end
        for (gi = 0; gi < NUM_DRAM; gi++) begin : g_dr
            assign dram_hit[gi] = dram_block_config[gi].valid &&
                ((req.addr & ~dram_block_config[gi].mask) ==
                 (dram_block_config[gi].base & ~dram_block_config[gi].mask));
        end
    endgenerate

    // access type per match count
    ebs_sel_t sel_new;
    always_comb begin
        sel_new = '0;
        sel_new.cs_hit = cs_hit;
        sel_new.dram_hit = dram_hit;
        sel_new.port_size = PORT_32;
        if (dram_hit != '0) begin
            // (RULE5) overlaps with dram are flagged, not resolved
            sel_new.acc = ($countones(dram_hit) == 1 && cs_hit == '0) ?
                EBS_ACC_DRAM : EBS_ACC_UNDEF;
        end else if ($countones(cs_hit) == 1) begin
            // (RULE2) single hit uses that window's settings
            sel_new.acc = EBS_ACC_CS;
            for (int i = 0; i < NUM_CS; i++) begin
                if (cs_hit[i]) begin
                    sel_new.int_ack = select_window_config[i].int_ack_en;
                    sel_new.burst = select_window_config[i].burst_en;
                    sel_new.port_size = select_window_config[i].port_size;
                    sel_new.wait_states = select_window_config[i].wait_states;
                end
            end
        end else begin
            // (RULE3) (RULE4) none or many: external ack, no burst, 32-bit
            sel_new.acc = EBS_ACC_EXT;
        end
    end

    // sequencer state; one clk per half bus clock
    ebs_state_t st_q, st_d;
    ebs_sel_t sel_q, sel_d;
    ebs_req_t req_q, req_d;
    logic [WAIT_W-1:0] wcnt_q, wcnt_d;
    logic iack_q, iack_d;
    logic [31:0] rdata_q, rdata_d;
    logic done_q, done_d;
    logic ready_q, ready_d;
    logic ack_seen;
    logic start;

    // internal ack counts as sampled ack when enabled
    // (RULE10) source of ack
    assign ack_seen = sel_q.int_ack ? iack_q : ~ack_s_q;
    assign start = req_valid && (st_q == EBS_IDLE || st_q == EBS_S5);

    always_comb begin
        st_d = st_q;
        sel_d = sel_q;
        req_d = req_q;
        wcnt_d = wcnt_q;
        iack_d = 1'b0;
        rdata_d = rdata_q;
        done_d = 1'b0;
        case (st_q)
            EBS_IDLE: begin
                if (start) begin
                    st_d = EBS_S0;
                    sel_d = sel_new;
                    req_d = req;
                    wcnt_d = WAIT_RESET;
                end
            end
            // (RULE12) S0 high phase
            EBS_S0: st_d = EBS_S1;
            EBS_S1: begin
                // (RULE15) fast termination skips S2/S3; not with internal ack
                // only the second sampling flop is read, so a target must hold
                // its ack low from before S0 for this path to be taken;
                // the extra latency buys freedom from metastable pin values
                if (!sel_q.int_ack && !ack_s_q) begin
                    st_d = EBS_S4;
                    rdata_d = din_s_q;
                    done_d = 1'b1;
                end else begin
                    st_d = EBS_S2;
                end
            end
            EBS_S2: begin
                st_d = EBS_S3;
                // (RULE25) internal ack after wait states
                iack_d = sel_q.int_ack && (wcnt_q == sel_q.wait_states);
            end
            EBS_S3: begin
                // (RULE7) (RULE9) sample with ack or add a wait clock
                if (ack_seen) begin
                    st_d = EBS_S4;
                    rdata_d = din_s_q;
                    done_d = 1'b1;
                end else begin
                    st_d = EBS_S2;
                    wcnt_d = wcnt_q + 1'b1;
                end
            end
            EBS_S4: st_d = EBS_S5;
            EBS_S5: begin
                // (RULE19) back-to-back starts straight at S0
                if (start) begin
                    st_d = EBS_S0;
                    sel_d = sel_new;
                    req_d = req;
                    wcnt_d = WAIT_RESET;
                end else begin
                    st_d = EBS_IDLE;
                end
            end
            default: st_d = EBS_IDLE;
        endcase
        // ready follows the state being entered, so the port leaves a flop
        // and still shows high exactly while idle or in S5
        ready_d = (st_d == EBS_IDLE || st_d == EBS_S5);
    end

    // (RULE24) reset to idle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= EBS_IDLE;
            sel_q <= '0;
            req_q <= '0;
            wcnt_q <= WAIT_RESET;
            iack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            done_q <= 1'b0;
            ready_q <= 1'b1;
        end else begin
            st_q <= st_d;
            sel_q <= sel_d;
            req_q <= req_d;
            wcnt_q <= wcnt_d;
            iack_q <= iack_d;
            rdata_q <= rdata_d;
            done_q <= done_d;
            ready_q <= ready_d;
        end
    end

    // pin values for the state being entered, so all outputs but the tied-off ack pins are flops
    logic bclk_d, as_d, oe_d, ts_d, tip_d, drv_d, dat_d, act_d;
    logic [NUM_CS-1:0] cs_d;
    always_comb begin
        // (RULE12) (RULE21) bus clock high on even states
        bclk_d = (st_d == EBS_S0 || st_d == EBS_S2 || st_d == EBS_S4 ||
                  st_d == EBS_IDLE) ? 1'b1 : 1'b0;
        act_d = (st_d != EBS_IDLE);
        // (RULE14) (RULE18) strobes on from S1 until S5 falling edge
        as_d = (st_d == EBS_S1 || st_d == EBS_S2 || st_d == EBS_S3 || st_d == EBS_S4);
        cs_d = as_d ? sel_d.cs_hit : '0;
        oe_d = as_d && !req_d.write;
        // (RULE13) (RULE16) start only in S0 and S1
        ts_d = (st_d == EBS_S0 || st_d == EBS_S1);
        // (RULE19) in-progress stays set through back-to-back S0
        tip_d = act_d;
        // (RULE6) (RULE11) address held through S5
        drv_d = act_d;
        // (RULE8) write data from end of first clock to cycle end
        dat_d = req_d.write && (st_d == EBS_S2 || st_d == EBS_S3 ||
                                st_d == EBS_S4 || st_d == EBS_S5 ||
                                (st_d == EBS_S4 && st_q == EBS_S1));
    end

    // output registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bus_clock_out <= 1'b1;
            addr_out <= ADDR_RESET;
            addr_oe_n <= 1'b1;
            read_write <= 1'b1;
            xfer_size_code <= SIZE_LONG;
            xfer_type_code <= TYPE_RESET;
            xfer_modifier_code <= MOD_RESET;
            transfer_start_n <= 1'b1;
            transfer_in_progress_n <= 1'b1;
            addr_strobe_n <= 1'b1;
            window_select_n <= '1;
            byte_lane_enable_n <= 4'hF;
            output_enable_n <= 1'b1;
            data_out <= 32'h0000_0000;
            data_oe_n <= 1'b1;
            dram_block_sel <= '0;
            undefined_access <= 1'b0;
        end else begin
            bus_clock_out <= bclk_d;
            addr_out <= drv_d ? req_d.addr : ADDR_RESET;
            addr_oe_n <= ~drv_d;
            // read/write left as is between cycles
            read_write <= drv_d ? ~req_d.write : read_write;
            // (RULE22) size code kept from request encoding
            xfer_size_code <= drv_d ? req_d.size : SIZE_LONG;
            // (RULE20) attributes only when pin config selects them
            xfer_type_code <= (drv_d && pin_assign_config[0]) ? req_d.ttype : TYPE_RESET;
            xfer_modifier_code <= (drv_d && pin_assign_config[1]) ? req_d.tmod : MOD_RESET;
            transfer_in_progress_n <= ~(tip_d && pin_assign_config[2]);
            transfer_start_n <= ~ts_d;
            addr_strobe_n <= ~as_d;
            window_select_n <= ~cs_d;
            byte_lane_enable_n <= as_d ? ~req_d.lanes : 4'hF;
            output_enable_n <= ~oe_d;
            data_out <= dat_d ? req_d.wdata : 32'h0000_0000;
            data_oe_n <= ~dat_d;
            dram_block_sel <= (act_d && sel_d.acc == EBS_ACC_DRAM) ? sel_d.dram_hit : '0;
            undefined_access <= act_d && (sel_d.acc == EBS_ACC_UNDEF);
        end
    end

    // handshake outputs; ack pin is input-only here, never driven
    assign req_ready = ready_q;
    assign done = done_q;
    assign rdata = rdata_q;
    assign transfer_ack_out_n = 1'b1;
    assign transfer_ack_oe_n = 1'b1;
endmodule
`default_nettype wire

//--- common/ebs_pkg.sv
// shared constants and types for the external bus cycle sequencer
package ebs_pkg;
    localparam int NUM_CS = 8;
    localparam int NUM_DRAM = 2;
    localparam int WAIT_W = 4;
    localparam int TIMEOUT_W = 8;
    localparam logic [1:0] SIZE_LONG = 2'h0;
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] SIZE_LINE = 2'h3;
    localparam logic [1:0] PORT_32 = 2'h0;
    localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
    localparam logic [1:0] TYPE_RESET = 2'h0;
    localparam logic [2:0] MOD_RESET = 3'h0;
    localparam logic [WAIT_W-1:0] WAIT_RESET = 4'h0;

    // access kind picked by the window decode
    typedef enum logic [1:0] {
        EBS_ACC_EXT = 2'b00,
        EBS_ACC_CS = 2'b01,
        EBS_ACC_DRAM = 2'b10,
        EBS_ACC_UNDEF = 2'b11
    } ebs_acc_t;

    // half-clock bus states
    typedef enum logic [2:0] {
        EBS_IDLE = 3'b000,
        EBS_S0 = 3'b001,
        EBS_S1 = 3'b010,
        EBS_S2 = 3'b011,
        EBS_S3 = 3'b100,
        EBS_S4 = 3'b101,
        EBS_S5 = 3'b110
    } ebs_state_t;

    // one chip-select window setting
    typedef struct packed {
        logic valid;
        logic [31:0] base;
        logic [31:0] mask;
        logic int_ack_en;
        logic burst_en;
        logic [1:0] port_size;
        logic [WAIT_W-1:0] wait_states;
    } ebs_win_t;

    // dram block window
    typedef struct packed {
        logic valid;
        logic [31:0] base;
        logic [31:0] mask;
    } ebs_dwin_t;

    // one access request from the core side
    typedef struct packed {
        logic [31:0] addr;
        logic write;
        logic [31:0] wdata;
        logic [1:0] size;
        logic [1:0] ttype;
        logic [2:0] tmod;
        logic [3:0] lanes;
    } ebs_req_t;

    // settings latched for a running cycle
    typedef struct packed {
        ebs_acc_t acc;
        logic [NUM_CS-1:0] cs_hit;
        logic [NUM_DRAM-1:0] dram_hit;
        logic int_ack;
        logic burst;
        logic [1:0] port_size;
        logic [WAIT_W-1:0] wait_states;
    } ebs_sel_t;
endpackage

//--- tb/ebs_seq_monitor.sv
// pin-level timing checks for the bus cycle sequencer
`timescale 1ns/1ns
`default_nettype none
module ebs_seq_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] pin_assign_config,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic done,
    input wire logic bus_clock_out,
    input wire logic addr_oe_n,
    input wire logic read_write,
    input wire logic [1:0] xfer_type_code,
    input wire logic transfer_start_n,
    input wire logic addr_strobe_n,
    input wire logic [ebs_pkg::NUM_CS-1:0] window_select_n,
    input wire logic data_oe_n
);
    import ebs_pkg::*;
    // one clock domain, so one clocking and one disable for all
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_reset_idle: assert property (
        !$past(rst_n) |-> addr_strobe_n && transfer_start_n && data_oe_n) else $error("not idle");
    chk_start_take: assert property (
        $fell(transfer_start_n) |-> $past(req_valid && req_ready) && bus_clock_out && !addr_oe_n)
        else $error("start without take");
    chk_start_width: assert property (
        $fell(transfer_start_n) |=> !transfer_start_n ##1 transfer_start_n) else $error("start width");
    chk_strobe_after: assert property (
        $fell(transfer_start_n) |=> $fell(addr_strobe_n) && !bus_clock_out) else $error("strobe late");
    chk_fall_phase: assert property (
        $changed(addr_strobe_n) || $changed(window_select_n) |-> !bus_clock_out)
        else $error("strobe on high phase");
    chk_select_span: assert property (
        window_select_n != '1 |-> !addr_strobe_n) else $error("select outside strobe");
    chk_done_bound: assert property (
        $fell(transfer_start_n) |-> ##[2:60] done) else $error("no done");
    chk_half_states: assert property (
        $fell(transfer_start_n) |-> bus_clock_out ##1 !bus_clock_out ##1 bus_clock_out)
        else $error("bus clock phase");
    chk_read_float: assert property (
        !addr_strobe_n && read_write |-> data_oe_n) else $error("driving on read");
    chk_write_hold: assert property (
        $rose(addr_strobe_n) && !read_write |-> !data_oe_n) else $error("write data dropped");
    chk_type_gate: assert property (
        !pin_assign_config[0] && !$past(pin_assign_config[0]) |-> xfer_type_code == 2'h0)
        else $error("type pins leak");
endmodule
`default_nettype wire

//--- tb/ebs_target_model.sv
// behavioural memory target on the external bus
`timescale 1ns/1ns
`default_nettype none
module ebs_target_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ack_en,
    input wire logic [3:0] ack_wait,
    input wire logic addr_strobe_n,
    input wire logic read_write,
    input wire logic [31:0] addr_out,
    input wire logic [31:0] data_out,
    input wire logic data_oe_n,
    output logic transfer_ack_n,
    output logic [31:0] data_in
);
    logic [31:0] mem [16];
    logic [31:0] last;
    logic [3:0] cnt;
    // ack after a chosen delay; held for two clocks only, then negated before strobe end
    always @(posedge clk) begin
        if (!rst_n || addr_strobe_n) begin
            cnt <= 4'h0;
            transfer_ack_n <= 1'h1;
        end else begin
            cnt <= cnt + 4'h1;
            // only externally terminated windows are acked
            // ack held two clocks so one whole-clock sample sees it, then negated
            transfer_ack_n <= !(ack_en && (cnt == ack_wait || cnt == ack_wait + 4'h1));
        end
        if (!addr_strobe_n && !read_write && !data_oe_n) mem[addr_out[5:2]] <= data_out;
        last <= rst_n ? data_in : 32'h0;
    end
    // drive only while the strobe is low on a read; a released bus shows churn
    assign data_in = (!addr_strobe_n && read_write) ? mem[addr_out[5:2]] : ~last;
endmodule
`default_nettype wire

//--- tb/ebs_sequencer_test.sv
// directed bench for the external bus cycle sequencer
`timescale 1ns/1ns
`default_nettype none
module ebs_sequencer_test;
    import ebs_pkg::*;
    logic clk = 1'h0;
    logic rst_n, req_valid, req_ready, done, bclk, as_n, tip_n, oe_n, ts_n, aoe_n;
    logic rw_l, doe_n, ack_n, ack_en, tip_prev;
    logic [31:0] rdata, addr, dout, din, rd_seen;
    logic [1:0] size, ttype, dsel, sz_seen, tt_seen, dr_seen;
    logic [7:0] cs_n, cs_seen;
    logic [2:0] tm, tm_seen;
    logic [3:0] be, be_seen;
    logic ud, ud_seen, oe_seen;
    logic [3:0] ack_wait;
    logic [2:0] pcfg;
    ebs_win_t [NUM_CS-1:0] win;
    ebs_dwin_t [NUM_DRAM-1:0] dwin;
    ebs_req_t req;
    int miscompares, num_checks, ndone, tgt, tip_rise, n;

    always #4 clk = ~clk;

    ebs_sequencer i_ebs_sequencer (.clk(clk), .rst_n(rst_n), .select_window_config(win),
        .dram_block_config(dwin), .pin_assign_config(pcfg), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .done(done), .rdata(rdata), .undefined_access(ud),
        .dram_block_sel(dsel), .bus_clock_out(bclk), .addr_out(addr), .addr_oe_n(aoe_n),
        .read_write(rw_l), .xfer_size_code(size), .xfer_type_code(ttype),
        .xfer_modifier_code(tm), .transfer_start_n(ts_n), .transfer_in_progress_n(tip_n),
        .addr_strobe_n(as_n), .window_select_n(cs_n), .byte_lane_enable_n(be),
        .output_enable_n(oe_n), .transfer_ack_n(ack_n), .data_in(din), .data_out(dout),
        .data_oe_n(doe_n), .transfer_ack_out_n(), .transfer_ack_oe_n());

    ebs_target_model i_ebs_target_model (.clk(clk), .rst_n(rst_n), .ack_en(ack_en),
        .ack_wait(ack_wait), .addr_strobe_n(as_n), .read_write(rw_l), .addr_out(addr),
        .data_out(dout), .data_oe_n(doe_n), .transfer_ack_n(ack_n), .data_in(din));

    // pin snapshot on the falling edge, clear of launch races
    always @(negedge clk) begin
        if (as_n === 1'h0) begin
            cs_seen <= cs_n;
            sz_seen <= size;
            tt_seen <= ttype;
            dr_seen <= dsel;
            tm_seen <= tm;
            be_seen <= be;
            oe_seen <= oe_n;
            ud_seen <= ud;
        end
        if (done === 1'h1) begin
            ndone++;
            rd_seen <= rdata;
        end
        if (tip_n === 1'h1 && tip_prev === 1'h0) tip_rise++;
        tip_prev <= tip_n;
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // present a request and hold it until the taking edge
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                        input logic [1:0] sz);
        int k;
        @(posedge clk);
        req <= '{a, w, d, sz, 2'h3, 3'h5, 4'hF};
        req_valid <= 1'h1;
        tgt++;
        k = 0;
        // ready judged mid-cycle, clear of the edge, then the taking edge passes
        @(negedge clk);
        while (req_ready !== 1'h1 && k < 50) begin
            @(negedge clk);
            k++;
        end
        if (k >= 50) miscompares++;
        @(posedge clk);
    endtask

    task automatic fin();
        int k;
        req_valid <= 1'h0;
        k = 0;
        while (ndone < tgt && k < 80) begin
            @(posedge clk);
            k++;
        end
        chk("done count", ndone, tgt);
    endtask

    task automatic rw(input logic [31:0] a, input logic [31:0] d, input logic [7:0] cs);
        xfer(a, 1'h1, d, SIZE_LONG);
        fin();
        chk("write oe", oe_seen, 32'h1);
        xfer(a, 1'h0, 32'h0, SIZE_LONG);
        fin();
        chk("rdata", rd_seen, d);
        chk("select", cs_seen, cs);
    endtask

    function automatic ebs_win_t mk(input logic [31:0] b, input logic ia, input logic [3:0] ws);
        mk = '{1'h1, b, 32'h00FF_FFFF, ia, 1'h1, PORT_32, ws};
    endfunction

    task automatic end_of_test();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        #20000;
        miscompares++;
        end_of_test();
    end

    initial begin
        rst_n = 1'h0;
        req_valid = 1'h0;
        req = '0;
        pcfg = 3'h7;
        ack_en = 1'h1;
        ack_wait = 4'h0;
        win = '0;
        dwin = '0;
        // dram block kept clear of every select window
        win[0] = mk(32'h1000_0000, 1'h0, 4'h0);
        win[1] = mk(32'h2000_0000, 1'h1, 4'h2);
        win[2] = mk(32'h3000_0000, 1'h0, 4'h0);
        win[3] = mk(32'h3000_0000, 1'h0, 4'h1);
        dwin[0] = '{1'h1, 32'h4000_0000, 32'h00FF_FFFF};
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        chk("idle pins", {as_n, ts_n, doe_n, bclk, oe_n}, 32'h1F);
        rw(32'h1000_0010, 32'hA5A5_0F0F, 8'hFE);
        ack_wait <= 4'h3;
        for (int s = 0; s < 4; s++) begin
            xfer(32'h1000_0010, 1'h0, 32'h0, s[1:0]);
            fin();
            chk("size", sz_seen, s);
            chk("type", tt_seen, 32'h3);
            chk("wait rdata", rd_seen, 32'hA5A5_0F0F);
            chk("read oe", oe_seen, 32'h0);
            chk("lanes", be_seen, 32'h0);
            chk("modifier", tm_seen, 32'h5);
        end
        ack_en <= 1'h0;
        rw(32'h2000_0020, 32'h1234_5678, 8'hFD);
        repeat (2) @(posedge clk);
        ack_en <= 1'h1;
        rw(32'h3000_0030, 32'h0BAD_F00D, 8'hF3);
        rw(32'h5000_0000, 32'h5555_AAAA, 8'hFF);
        rw(32'h4000_0040, 32'h0F0F_F0F0, 8'hFF);
        chk("dram", dr_seen, 32'h1);
        chk("undefined", ud_seen, 32'h0);
        pcfg <= 3'h0;
        xfer(32'h1000_0010, 1'h0, 32'h0, SIZE_WORD);
        fin();
        chk("type off", tt_seen, 32'h0);
        chk("modifier off", tm_seen, 32'h0);
        pcfg <= 3'h7;
        n = tip_rise;
        xfer(32'h1000_0014, 1'h1, 32'hC3C3_3C3C, SIZE_LONG);
        xfer(32'h1000_0014, 1'h0, 32'h0, SIZE_LONG);
        fin();
        chk("tip gap", tip_rise, n);
        chk("b2b rdata", rd_seen, 32'hC3C3_3C3C);
        end_of_test();
    end
endmodule

bind ebs_sequencer ebs_seq_monitor i_ebs_seq_monitor (.clk(clk), .rst_n(rst_n),
    .pin_assign_config(pin_assign_config), .req_valid(req_valid), .req_ready(req_ready),
    .done(done), .bus_clock_out(bus_clock_out), .addr_oe_n(addr_oe_n),
    .read_write(read_write), .xfer_type_code(xfer_type_code),
    .transfer_start_n(transfer_start_n), .addr_strobe_n(addr_strobe_n),
    .window_select_n(window_select_n), .data_oe_n(data_oe_n));
`default_nettype wire
